/* rtl/esrb_bank.v */
// Erratum status register bank: count register plus status words.
// Assumes a registered model-specific-register access path on core_clk;
// a firmware write strobe distinguishes firmware stores from others.
// Summary of operation
// - The bank sits at a fixed base, count register first, status words at following addresses.
// - The count register holds the number of valid vector bits in 15:0 and reads zero above.
// - Status word N holds vector bits (N-1)*64 up to (N-1)*64+63.
// - Identifier n lives in the word at base plus one plus n divided by 64.
// - Inside that word, identifier n sits at bit n modulo 64.
// - A one means the erratum is present and a workaround is needed.
// - A zero means the erratum is fixed and any workaround must be disabled.
// - Bits past the last valid vector position read as reserved zero.
// - Firmware writes to every register of the bank are accepted.
// - Identifiers run from zero to count minus one and are never reused.
// - A feature flag reads one whenever the bank is present.
`timescale 1ns/1ps
`include "esrb_regs.vh"
module esrb_bank #(
  parameter WORDS = `ESRB_STATUS_WORDS,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // Register access path
  input  wire [31:0] reg_addr,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire        reg_fw,
  input  wire [63:0] reg_wdata,
  output reg  [63:0] reg_rdata,
  output reg         reg_rvalid,
  output reg         reg_hit,
  // Feature identification
  output wire        workaround_visibility_flag
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function [32:0] esrb_index;
    input [31:0] a;
    begin
      esrb_index = {1'b0, a} - {1'b0, `ESRB_BASE_ADDR};
    end
  endfunction

  wire [32:0] rd_idx    = esrb_index(reg_addr);
  wire        in_bank   = !rd_idx[32] && (rd_idx[31:0] <= WORDS);
  wire        is_count  = in_bank && (rd_idx[31:0] == 32'h00000000);
  wire        is_status = in_bank && !is_count;
  wire [31:0] word_idx  = rd_idx[31:0] - 32'h00000001;
  wire [AW-1:0] mem_addr = word_idx[AW-1:0];

  reg  [15:0] valid_erratum_count;
  wire [63:0] mem_rdata;
  reg         rd_count_q;
  reg         rd_status_q;
  reg  [AW-1:0] rd_word_q;

  // OS writes are dropped without trace; only firmware may store
  wire fw_write = reg_wr && reg_fw && in_bank;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      valid_erratum_count <= `ESRB_COUNT_RESET;
    end else if (fw_write && is_count) begin
      valid_erratum_count <= reg_wdata[`ESRB_COUNT_MSB:`ESRB_COUNT_LSB];
    end
  end

  esrb_status_mem #(
    .WORDS (WORDS),
    .AW    (AW),
    .WIDTH (`ESRB_WORD_BITS)
  ) u_mem (
    .core_clk (core_clk),
    .wr_en    (fw_write && is_status),
    .wr_addr  (mem_addr),
    .wr_data  (reg_wdata),
    .rd_addr  (mem_addr),
    .rd_data  (mem_rdata)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Bit b of word w is identifier w*64+b; mask positions at or past count
  function [63:0] esrb_valid_mask;
    input [AW-1:0] w;
    input [15:0]   cnt;
    integer        b;
    reg   [31:0]   id;
    begin
      esrb_valid_mask = 64'h0000000000000000;
      for (b = 0; b < 64; b = b + 1) begin
        id = ({{(32-AW){1'b0}}, w} << `ESRB_WORD_SHIFT) + b;
        esrb_valid_mask[b] = (id < {16'h0000, cnt});
      end
    end
  endfunction

  always @(posedge core_clk) begin
    if (!reset_n) begin
      rd_count_q  <= 1'b0;
      rd_status_q <= 1'b0;
      rd_word_q   <= {AW{1'b0}};
      reg_rvalid  <= 1'b0;
      reg_hit     <= 1'b0;
    end else begin
      rd_count_q  <= reg_rd && is_count;
      rd_status_q <= reg_rd && is_status;
      rd_word_q   <= mem_addr;
      reg_rvalid  <= reg_rd;
      reg_hit     <= reg_rd && in_bank;
    end
  end

  // Read is pure: neither the count register nor the status memory contents depend on reg_rd
  always @* begin
    if (rd_count_q) begin
      reg_rdata = {48'h000000000000, valid_erratum_count};
    end else if (rd_status_q) begin
      reg_rdata = mem_rdata & esrb_valid_mask(rd_word_q, valid_erratum_count);
    end else begin
      reg_rdata = 64'h0000000000000000;
    end
  end

  assign workaround_visibility_flag = `ESRB_PRESENT;
endmodule // esrb_bank

/* rtl/esrb_regs.vh */
// Constants for the erratum status register bank.
// Assumes inclusion by the bank, its checker and its bench.
`ifndef ESRB_REGS_VH
`define ESRB_REGS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define ESRB_BASE_ADDR      32'hC0010140
`define ESRB_COUNT_LSB      0
`define ESRB_COUNT_MSB      15
`define ESRB_WORD_BITS      64
`define ESRB_WORD_SHIFT     6
`define ESRB_STATUS_WORDS   4
`define ESRB_COUNT_RESET    16'h0000
`define ESRB_STATUS_RESET   64'h0000000000000000
`define ESRB_PRESENT        1'b1

`endif

/* rtl/esrb_status_mem.v */
// Storage for the erratum status words.
// Assumes one clock; read data registered, one cycle behind the address.
`timescale 1ns/1ps
module esrb_status_mem #(
  parameter WORDS  = 4,
  parameter AW     = 2,
  parameter WIDTH  = 64
) (
  // Clock
  input  wire             core_clk,
  // Write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Read port
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:WORDS-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // esrb_status_mem

/* tb/esrb_bank_assertions.sv */
// Port checker for the erratum status bank.
// Assumes one clock; bound onto esrb_bank below.
`timescale 1ns/1ps
`include "esrb_regs.vh"
module esrb_chk (
  input wire        core_clk, reset_n, reg_rd, reg_wr, reg_fw, reg_rvalid, reg_hit,
  input wire        workaround_visibility_flag,
  input wire [31:0] reg_addr,
  input wire [63:0] reg_wdata, reg_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_cnt_rd; reg_rd && reg_addr == `ESRB_BASE_ADDR; endsequence
  sequence s_cnt_wr; reg_wr && reg_fw && reg_addr == `ESRB_BASE_ADDR; endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid && !reg_hit) else $error("stray");
  a_flag_set: assert property (workaround_visibility_flag) else $error("flag low");
  a_hit_decode: assert property (reg_rvalid |-> reg_hit == ($past(reg_addr) - `ESRB_BASE_ADDR <= 32'h4))
    else $error("decode");
  a_miss_zero: assert property (reg_rvalid && !reg_hit |-> reg_rdata == 64'h0) else $error("miss");
  a_cnt_upper: assert property (reg_rvalid && $past(reg_addr) == `ESRB_BASE_ADDR |->
    reg_rdata[63:16] == 48'h0) else $error("upper");
  a_cnt_store: assert property (s_cnt_wr ##1 s_cnt_rd |=>
    reg_rdata[15:0] == $past(reg_wdata[15:0], 2)) else $error("store");
  a_os_ignored: assert property (s_cnt_rd ##1 (reg_wr && !reg_fw) ##1 s_cnt_rd |=>
    reg_rdata == $past(reg_rdata, 2)) else $error("os write");
endmodule // esrb_chk
bind esrb_bank esrb_chk esrb_chk_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_fw(reg_fw), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .reg_addr(reg_addr),
  .workaround_visibility_flag(workaround_visibility_flag), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

/* tb/esrb_bank_tb.sv */
// Self-checking bench for the erratum status bank.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "esrb_regs.vh"
module esrb_bank_tb;
  reg         core_clk, reset_n, reg_rd, reg_wr, reg_fw;
  reg  [31:0] reg_addr;
  reg  [63:0] reg_wdata, st [1:4];
  reg  [15:0] cnt;
  reg  [64:0] q [$];
  wire [63:0] reg_rdata;
  wire        reg_rvalid, reg_hit, flag;
  integer     fail_count = 0, samples_checked = 0, cyc = 0, k, b;
  esrb_bank esrb_bank_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_fw(reg_fw), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .workaround_visibility_flag(flag));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input [64:0] seen, input [64:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Status bits past the count read as zero
  // Own loop index: the caller's loops use b and must not be disturbed
  function [64:0] expw(input [2:0] i);
    integer j;
    begin
      expw = {i < 5, 64'h0};
      if (i == 0) expw[15:0] = cnt;
      else if (i < 5) for (j = 0; j < 64; j = j + 1) expw[j] = st[i][j] && ((i - 1) * 64 + j < cnt);
    end
  endfunction
  // One access per cycle; the model follows only accepted writes
  task op(input rd, input wr, input fw, input [2:0] i, input [63:0] d);
    begin
      reg_rd = rd;
      reg_wr = wr;
      reg_fw = fw;
      reg_addr = `ESRB_BASE_ADDR + i;
      reg_wdata = d;
      if (rd) q.push_back(expw(i));
      if (wr && fw && i == 0) cnt = d[15:0];
      if (wr && fw && i > 0 && i < 5) st[i] = d;
      @(negedge core_clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(negedge core_clk) begin
    cyc = cyc + 1;
    if (reg_rvalid === 1'b1) chk({reg_hit, reg_rdata}, q.pop_front());
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    k = $urandom(53);
    reset_n = 1'b0;
    repeat (16) op(0, 0, 0, 0, 64'h0);
    reset_n = 1'b1;
    chk({64'h0, flag}, 65'h1);
    for (k = 1; k < 5; k = k + 1) op(0, 1, 1, k, {$urandom, $urandom});
    // Random count with junk above bit 15, then 64 and 0 as edges
    for (k = 0; k < 4; k = k + 1) begin
      op(0, 1, 1, 0, {$urandom, k == 2 ? 32'd64 : k == 3 ? 32'd0 : $urandom_range(255, 1)});
      for (b = 0; b < 6; b = b + 1) op(1, 0, 0, b, 64'h0);
      op(0, 1, 0, k + 1, {$urandom, $urandom});
      op(1, 0, 0, 0, 64'h0);
      op(0, 1, 0, 0, {$urandom, $urandom});
      op(1, 0, 0, 0, 64'h0);
      op(0, 1, 1, 5, {$urandom, $urandom});
      op(1, 0, 0, k + 1, 64'h0);
    end
    // Count grows by one, exposing bit 63 of word one; then two fixed errata, bits 0 and 63 of word one, are cleared
    op(0, 1, 1, 0, 64'h000000000000003F);
    op(0, 1, 1, 0, {48'h000000000000, cnt + 16'h0001});
    op(1, 0, 0, 0, 64'h0);
    op(1, 0, 0, 1, 64'h0);
    op(0, 1, 1, 1, st[1] & ~64'h8000000000000001);
    op(1, 0, 0, 1, 64'h0);
    repeat (3) op(0, 0, 0, 0, 64'h0);
    tally_and_finish;
  end
endmodule // esrb_bank_tb
